// ### hdl/csr_core_registers.sv
// core special-function registers with indirect ports, flags and avalon slave
`timescale 1ns/100ps
module csr_core_registers
   import csr_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire csr_avl_req_t avl_req,
   output csr_avl_rsp_t avl_rsp,
   input wire csr_core_op_t core_op,
   output csr_core_out_t core_out
);

   // ==========================================================
   // helpers

   // address of one of the three indirect ports
   function automatic logic csr_is_port(input logic [7:0] addr);
      csr_is_port = (addr == IDX_PORT_BANK0) || (addr == IDX_PORT_ONE) ||
         (addr == IDX_PORT_TWO);
   endfunction

   // map a bus index to the location actually accessed
   function automatic csr_target_t csr_resolve(
      input logic bank,
      input logic [7:0] addr,
      input logic [7:0] p0,
      input logic [7:0] p1_low,
      input logic [7:0] p1_bank,
      input logic [7:0] p2_low,
      input logic [7:0] p2_bank
   );
      csr_target_t t;
      t.kind = ACC_SFR;
      t.bank = bank;
      t.addr = addr;
      // indirect port goes through its pointer
      if (addr == IDX_PORT_BANK0) begin
         t.bank = 1'b0;
         t.addr = p0;
      end else if (addr == IDX_PORT_ONE) begin
         t.bank = p1_bank[0];
         t.addr = p1_low;
      end else if (addr == IDX_PORT_TWO) begin
         t.bank = p2_bank[0];
         t.addr = p2_low;
      end
      // port reached via a pointer is not real storage
      if (csr_is_port(addr) && csr_is_port(t.addr)) begin
         t.kind = ACC_NULL;
      end else if (t.addr >= IDX_GENERAL_BASE) begin
         t.kind = ACC_MEM;
      end else begin
         t.kind = ACC_SFR;
      end
      return t;
   endfunction

   // ==========================================================
   // state and memory connections
   csr_state_t st;
   csr_state_t next_st;
   csr_target_t live_target;
   logic [RAM_ADDR_W-1:0] mem_addr;
   logic mem_wen;
   logic [7:0] mem_rdata;
   logic [7:0] sfr_rdata;
   logic [7:0] flags;
   logic wrap;
   logic zero;

   csr_data_ram u_ram (
      .clock(clock),
      .addr(mem_addr),
      .write_enable(mem_wen),
      .write_data(st.wdata),
      .read_data(mem_rdata)
   );

   // ==========================================================
   // register readback for the latched target
   always_comb begin
      sfr_rdata = INDIRECT_NULL_DATA;
      case (st.target.addr)
         IDX_POINTER_BANK0: begin
            sfr_rdata = st.pointer_bank0;
         end
         IDX_POINTER_ONE_LOW: begin
            sfr_rdata = st.pointer_one_low;
         end
         IDX_POINTER_ONE_BANK: begin
            sfr_rdata = st.pointer_one_bank;
         end
         IDX_POINTER_TWO_LOW: begin
            sfr_rdata = st.pointer_two_low;
         end
         IDX_POINTER_TWO_BANK: begin
            sfr_rdata = st.pointer_two_bank;
         end
         IDX_WORKING: begin
            sfr_rdata = st.working_register;
         end
         IDX_PC_LOW: begin
            sfr_rdata = core_op.pc_now[7:0];
         end
         IDX_TABLE_LOW: begin
            sfr_rdata = st.table_pointer_low;
         end
         IDX_TABLE_HIGH: begin
            sfr_rdata = st.table_pointer_high;
         end
         IDX_TABLE_BYTE: begin
            sfr_rdata = st.table_high_byte;
         end
         IDX_STATUS: begin
            sfr_rdata = st.status;
         end
         default: begin
            sfr_rdata = INDIRECT_NULL_DATA;
         end
      endcase
   end

   // ==========================================================
   // next state: bus phases, then core updates
   always_comb begin
      next_st = st;
      flags = STATUS_RESET;
      wrap = 1'b0;
      zero = 1'b0;
      live_target = csr_resolve(avl_req.address[BUS_ADDR_W-1], avl_req.address[9:2],
         st.pointer_bank0, st.pointer_one_low, st.pointer_one_bank,
         st.pointer_two_low, st.pointer_two_bank);
      mem_wen = 1'b0;
      mem_addr = {live_target.bank, live_target.addr[6:0]};
      next_st.core_out.jump = 1'b0;
      // one dummy cycle follows every jump
      next_st.core_out.dummy_cycle = st.core_out.jump;

      // avalon slave phases
      case (st.phase)
         PH_IDLE: begin
            next_st.avl_rsp.waitrequest = 1'b1;
            if (avl_req.read || avl_req.write) begin
               next_st.target = live_target;
               next_st.is_write = avl_req.write && avl_req.byteenable[0];
               next_st.wdata = avl_req.writedata[7:0];
               next_st.phase = PH_FETCH;
            end
         end
         PH_FETCH: begin
            // answer now, commit a write at the accepting edge
            next_st.avl_rsp.waitrequest = 1'b0;
            next_st.phase = PH_DONE;
            if (st.target.kind == ACC_MEM) begin
               next_st.avl_rsp.readdata = {READ_PAD, mem_rdata};
            end else if (st.target.kind == ACC_SFR) begin
               next_st.avl_rsp.readdata = {READ_PAD, sfr_rdata};
            end else begin
               next_st.avl_rsp.readdata = {READ_PAD, INDIRECT_NULL_DATA};
            end
         end
         PH_DONE: begin
            next_st.avl_rsp.waitrequest = 1'b1;
            next_st.phase = PH_IDLE;
            mem_addr = {st.target.bank, st.target.addr[6:0]};
            if (st.is_write && st.target.kind == ACC_MEM) begin
               mem_wen = 1'b1;
            end else if (st.is_write && st.target.kind == ACC_SFR) begin
               case (st.target.addr)
                  IDX_POINTER_BANK0: begin
                     next_st.pointer_bank0 = st.wdata;
                  end
                  IDX_POINTER_ONE_LOW: begin
                     next_st.pointer_one_low = st.wdata;
                  end
                  IDX_POINTER_ONE_BANK: begin
                     next_st.pointer_one_bank = st.wdata;
                  end
                  IDX_POINTER_TWO_LOW: begin
                     next_st.pointer_two_low = st.wdata;
                  end
                  IDX_POINTER_TWO_BANK: begin
                     next_st.pointer_two_bank = st.wdata;
                  end
                  IDX_WORKING: begin
                     next_st.working_register = st.wdata;
                  end
                  IDX_PC_LOW: begin
                     // jump inside the current page
                     next_st.core_out.jump = 1'b1;
                     next_st.core_out.jump_target = {core_op.pc_now[PC_W-1:8], st.wdata};
                  end
                  IDX_TABLE_LOW: begin
                     next_st.table_pointer_low = st.wdata;
                  end
                  IDX_TABLE_HIGH: begin
                     next_st.table_pointer_high = st.wdata;
                  end
                  IDX_STATUS: begin
                     // sleep and expiry bits are read-only
                     next_st.status = (st.status & ~STATUS_WRITE_MASK) |
                        (st.wdata & STATUS_WRITE_MASK);
                  end
                  default: begin
                     next_st.status = next_st.status;
                  end
               endcase
            end
         end
         default: begin
            next_st.phase = PH_IDLE;
            next_st.avl_rsp.waitrequest = 1'b1;
         end
      endcase

      // alu result lands in the working register
      if (core_op.load_working) begin
         next_st.working_register = core_op.result;
      end

      // table read: high byte kept, low byte handed to the core
      if (core_op.table_read) begin
         next_st.table_high_byte = core_op.table_word[15:8];
         next_st.core_out.table_low_data = core_op.table_word[7:0];
      end

      // arithmetic flags from the alu, applied after a software write
      flags = next_st.status;
      zero = (core_op.result == 8'h00);
      wrap = core_op.msb_carry_in ^ core_op.carry_out;
      case (core_op.alu_kind)
         ALU_ADD, ALU_SUB, ALU_SBC: begin
            flags[FLAG_CARRY] = core_op.carry_out;
            flags[FLAG_NIBBLE] = core_op.nibble_carry;
            flags[FLAG_ZERO] = zero;
            flags[FLAG_SIGNED_WRAP] = wrap;
            flags[FLAG_SIGN_XOR] = wrap ^ core_op.result[7];
            if (core_op.alu_kind == ALU_SUB) begin
               flags[FLAG_CHAINED_NULL] = zero;
            end else if (core_op.alu_kind == ALU_SBC) begin
               flags[FLAG_CHAINED_NULL] = flags[FLAG_CHAINED_NULL] & zero;
            end
         end
         ALU_LOGIC: begin
            flags[FLAG_ZERO] = zero;
         end
         ALU_ROTATE: begin
            flags[FLAG_CARRY] = core_op.carry_out;
         end
         default: begin
            flags = next_st.status;
         end
      endcase

      // sleep flag: refresh clears, halt sets
      if (core_op.halt) begin
         flags[FLAG_SLEEP] = 1'b1;
      end else if (core_op.watchdog_refresh) begin
         flags[FLAG_SLEEP] = 1'b0;
      end

      // expiry flag: timeout wins over a clear in the same cycle
      if (core_op.watchdog_timeout) begin
         flags[FLAG_WATCHDOG_EXPIRY] = 1'b1;
      end else if (core_op.halt || core_op.watchdog_refresh) begin
         flags[FLAG_WATCHDOG_EXPIRY] = 1'b0;
      end
      // single update point, nothing pushes status on a call
      next_st.status = flags;

      // core facing copies, registered with their sources
      next_st.core_out.working_register = next_st.working_register;
      next_st.core_out.table_address = {next_st.table_pointer_high,
         next_st.table_pointer_low};
      next_st.core_out.status = next_st.status;
   end

   // ==========================================================
   // state register, flags cleared at power-up
   always_ff @(posedge clock) begin
      if (reset) begin
         st <= '0;
         st.phase <= PH_IDLE;
         st.target.kind <= ACC_SFR;
         st.pointer_bank0 <= REG_RESET;
         st.working_register <= REG_RESET;
         st.status <= STATUS_RESET;
         st.avl_rsp.waitrequest <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign avl_rsp = st.avl_rsp;
   assign core_out = st.core_out;

endmodule

// ### hdl/csr_pkg.sv
// constants, types and carriers of the core special-function register block
//
// Summary of operation
// - indirect port accesses go to the location held in its pointer instead
// - first port reaches bank 0 only; second and third reach any bank
// - high pointer byte picks the bank used by its indirect port
// - indirect port reached through a pointer reads 00h, write is ignored
// - all five pointer bytes are plain readable and writable registers
// - direct addressing reaches the whole data space of every bank
// - working register holds alu results; transfers pass through it
// - writing program counter low jumps, upper counter bits kept
// - loading program counter low adds one dummy cycle
// - table pointers give the table address; software sets and steps them
// - table read puts high byte in table_high_byte, low byte to destination
// - status register is eight bits holding eight flags
// - software status writes change arithmetic flags, not sleep or expiry
// - carry set on carry out or no borrow; rotates update it
// - nibble flag set on low nibble carry or no nibble borrow
// - zero flag set when result is zero, else cleared
// - signed wrap flag is carry into msb xor carry out of msb
// - sleep flag: reset and refresh clear, halt sets, nothing else
// - expiry flag: reset, refresh, halt clear; watchdog timeout sets
// - sign-xor flag is signed wrap flag xor result msb
// - status is never saved automatically on interrupt or call
package csr_pkg;

   // ==========================================================
   // data memory map, register index (byte address is four times)
   localparam logic [7:0] IDX_PORT_BANK0 = 8'h00;
   localparam logic [7:0] IDX_POINTER_BANK0 = 8'h01;
   localparam logic [7:0] IDX_PORT_ONE = 8'h02;
   localparam logic [7:0] IDX_POINTER_ONE_LOW = 8'h03;
   localparam logic [7:0] IDX_POINTER_ONE_BANK = 8'h04;
   localparam logic [7:0] IDX_WORKING = 8'h05;
   localparam logic [7:0] IDX_PC_LOW = 8'h06;
   localparam logic [7:0] IDX_TABLE_LOW = 8'h07;
   localparam logic [7:0] IDX_TABLE_HIGH = 8'h08;
   localparam logic [7:0] IDX_TABLE_BYTE = 8'h09;
   localparam logic [7:0] IDX_STATUS = 8'h0A;
   localparam logic [7:0] IDX_PORT_TWO = 8'h0C;
   localparam logic [7:0] IDX_POINTER_TWO_LOW = 8'h0D;
   localparam logic [7:0] IDX_POINTER_TWO_BANK = 8'h0E;
   localparam logic [7:0] IDX_GENERAL_BASE = 8'h80;

   // ==========================================================
   // widths
   localparam int BUS_ADDR_W = 11;
   localparam int PC_W = 12;
   localparam int RAM_ADDR_W = 8;

   // ==========================================================
   // status bit positions
   localparam int FLAG_SIGN_XOR = 7;
   localparam int FLAG_CHAINED_NULL = 6;
   localparam int FLAG_WATCHDOG_EXPIRY = 5;
   localparam int FLAG_SLEEP = 4;
   localparam int FLAG_SIGNED_WRAP = 3;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_NIBBLE = 1;
   localparam int FLAG_CARRY = 0;
   localparam logic [7:0] STATUS_WRITE_MASK = 8'hCF;

   // ==========================================================
   // reset values and fixed answers
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] INDIRECT_NULL_DATA = 8'h00;
   localparam logic [23:0] READ_PAD = 24'h00_0000;

   // ==========================================================
   // enumerations
   typedef enum logic [2:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_ROTATE
   } csr_alu_kind_t;

   typedef enum logic [1:0] {ACC_SFR, ACC_MEM, ACC_NULL} csr_access_kind_t;

   typedef enum logic [1:0] {PH_IDLE, PH_FETCH, PH_DONE} csr_phase_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [BUS_ADDR_W-1:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } csr_avl_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } csr_avl_rsp_t;

   typedef struct packed {
      csr_alu_kind_t alu_kind;
      logic [7:0] result;
      logic carry_out;
      logic nibble_carry;
      logic msb_carry_in;
      logic load_working;
      logic halt;
      logic watchdog_refresh;
      logic watchdog_timeout;
      logic table_read;
      logic [15:0] table_word;
      logic [PC_W-1:0] pc_now;
   } csr_core_op_t;

   typedef struct packed {
      logic [7:0] working_register;
      logic [15:0] table_address;
      logic [7:0] table_low_data;
      logic jump;
      logic [PC_W-1:0] jump_target;
      logic dummy_cycle;
      logic [7:0] status;
   } csr_core_out_t;

   typedef struct packed {
      csr_access_kind_t kind;
      logic bank;
      logic [7:0] addr;
   } csr_target_t;

   typedef struct packed {
      csr_phase_t phase;
      csr_target_t target;
      logic is_write;
      logic [7:0] wdata;
      logic [7:0] pointer_bank0;
      logic [7:0] pointer_one_low;
      logic [7:0] pointer_one_bank;
      logic [7:0] pointer_two_low;
      logic [7:0] pointer_two_bank;
      logic [7:0] working_register;
      logic [7:0] table_pointer_low;
      logic [7:0] table_pointer_high;
      logic [7:0] table_high_byte;
      logic [7:0] status;
      csr_avl_rsp_t avl_rsp;
      csr_core_out_t core_out;
   } csr_state_t;

endpackage

// ### hdl/csr_data_ram.sv
// general purpose data memory, both banks, registered read data
`timescale 1ns/100ps
module csr_data_ram
   import csr_pkg::*;
(
   input wire logic clock,
   input wire logic [RAM_ADDR_W-1:0] addr,
   input wire logic write_enable,
   input wire logic [7:0] write_data,
   output logic [7:0] read_data
);

   // ==========================================================
   // storage
   logic [7:0] cells [0:(1<<RAM_ADDR_W)-1];

   // write on enable, read word always registered
   always_ff @(posedge clock) begin
      if (write_enable) begin
         cells[addr] <= write_data;
      end
      read_data <= cells[addr];
   end

endmodule

// ### tb/csr_core_registers_monitor.sv
// checker on the ports of the core special register block
`timescale 1ns/100ps
module csr_core_registers_monitor
   import csr_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire csr_avl_req_t avl_req,
   input wire csr_avl_rsp_t avl_rsp,
   input wire csr_core_op_t core_op,
   input wire csr_core_out_t core_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic arith;
   logic sys;
   logic [7:0] st;
   // ==========================================
   // helpers: arithmetic kinds, system pulses
   assign arith = core_op.alu_kind inside {ALU_ADD, ALU_SUB, ALU_SBC};
   assign sys = core_op.halt | core_op.watchdog_refresh | core_op.watchdog_timeout;
   assign st = core_out.status;
   a_bus_answer: assert property ($rose(avl_req.read | avl_req.write)
      |-> avl_rsp.waitrequest ##1 avl_rsp.waitrequest ##1 !avl_rsp.waitrequest)
      else $error("bus answer not two cycles after request");
   a_pc_jump: assert property (avl_req.write && !avl_rsp.waitrequest
      && avl_req.byteenable[0] && avl_req.address[9:2] == IDX_PC_LOW |=> core_out.jump
      && core_out.jump_target[7:0] == $past(avl_req.writedata[7:0]))
      else $error("program counter low write gave no jump");
   a_dummy_after: assert property (core_out.jump |=> core_out.dummy_cycle)
      else $error("no dummy cycle after jump");
   a_sys_held: assert property (!sys |=> $stable(st[5:4]))
      else $error("sleep or expiry flag changed without cause");
   a_halt_sleep: assert property (core_op.halt |=> st[FLAG_SLEEP])
      else $error("halt did not set sleep flag");
   a_expiry_set: assert property (core_op.watchdog_timeout |=> st[5])
      else $error("timeout did not set expiry flag");
   a_expiry_clear: assert property ((core_op.halt | core_op.watchdog_refresh)
      && !core_op.watchdog_timeout |=> !st[FLAG_WATCHDOG_EXPIRY])
      else $error("expiry flag not cleared");
   a_zero_flag: assert property (arith || core_op.alu_kind == ALU_LOGIC
      |=> st[FLAG_ZERO] == ($past(core_op.result) == 8'h00))
      else $error("zero flag wrong");
   a_carry_flags: assert property (arith |=> st[0] == $past(core_op.carry_out)
      && st[FLAG_NIBBLE] == $past(core_op.nibble_carry))
      else $error("carry or nibble flag wrong");
   a_wrap_sign: assert property (arith
      |=> st[3] == $past(core_op.msb_carry_in ^ core_op.carry_out)
      && st[7] == (st[3] ^ $past(core_op.result[7])))
      else $error("wrap or sign flag wrong");
   a_chain_flag: assert property (core_op.alu_kind == ALU_SBC
      |=> st[6] == ($past(st[6]) && st[2]))
      else $error("chained flag wrong after borrow subtract");
   a_table_low: assert property (core_op.table_read
      |=> core_out.table_low_data == $past(core_op.table_word[7:0]))
      else $error("table low byte wrong");
   a_working_load: assert property (core_op.load_working
      |=> core_out.working_register == $past(core_op.result))
      else $error("working register not loaded");
   c_jump: cover property (core_out.jump);
   c_borrow_sub: cover property (core_op.alu_kind == ALU_SBC);
   c_timeout: cover property (core_op.watchdog_timeout);
endmodule

bind csr_core_registers csr_core_registers_monitor csr_core_registers_monitor_i (
   .clock(clock), .reset(reset), .avl_req(avl_req), .avl_rsp(avl_rsp),
   .core_op(core_op), .core_out(core_out));

// ### tb/csr_core_model.sv
// processor core model driving alu results, system pulses and table words
`timescale 1ns/100ps
module csr_core_model
   import csr_pkg::*;
(
   input wire logic clock,
   output csr_core_op_t core_op
);
   localparam logic [PC_W-1:0] PC_NOW = 12'hA00;
   // ==========================================
   // quiet op keeps the program counter steady
   function automatic csr_core_op_t idle_op();
      idle_op = '0;
      idle_op.pc_now = PC_NOW;
   endfunction
   initial core_op = idle_op();
   // one op for one cycle, then a quiet cycle
   task automatic issue(input csr_core_op_t op);
      core_op <= op;
      @(posedge clock);
      core_op <= idle_op();
      @(posedge clock);
   endtask
   // subtract adds the inverted operand plus carry in
   task automatic alu(input csr_alu_kind_t k, input logic [7:0] a, b, input logic c);
      csr_core_op_t op;
      logic [7:0] y;
      logic [8:0] s;
      logic [4:0] n;
      logic [7:0] m;
      op = idle_op();
      y = (k == ALU_ADD) ? b : ~b;
      s = {1'b0, a} + {1'b0, y} + 9'(c);
      n = {1'b0, a[3:0]} + {1'b0, y[3:0]} + 5'(c);
      m = {1'b0, a[6:0]} + {1'b0, y[6:0]} + 8'(c);
      op.alu_kind = k;
      op.result = s[7:0];
      op.carry_out = s[8];
      op.nibble_carry = n[4];
      op.msb_carry_in = m[7];
      op.load_working = 1'b1;
      if (k == ALU_LOGIC) begin
         op.result = a;
      end
      if (k == ALU_ROTATE) begin
         op.result = {a[6:0], c};
         op.carry_out = a[7];
      end
      issue(op);
   endtask
   // halt, refresh and timeout pulses
   task automatic pulse(input logic h, r, t);
      csr_core_op_t op;
      op = idle_op();
      op.halt = h;
      op.watchdog_refresh = r;
      op.watchdog_timeout = t;
      issue(op);
   endtask
   // fetched program word at the table address
   task automatic table_fetch(input logic [15:0] w);
      csr_core_op_t op;
      op = idle_op();
      op.table_read = 1'b1;
      op.table_word = w;
      issue(op);
   endtask
endmodule

// ### tb/core_special_registers_tb_top.sv
// self-checking bench for the core special register block
`timescale 1ns/100ps
`define CHK(act, exp) begin \
   comparisons++; \
   if ((act) !== (exp)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, (act), (exp)); \
   end \
end
module core_special_registers_tb_top
   import csr_pkg::*;
   ;
   logic clock;
   logic reset;
   csr_avl_req_t avl_req;
   csr_avl_rsp_t avl_rsp;
   csr_core_op_t core_op;
   csr_core_out_t core_out;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // ==========================================
   // design and core model
   csr_core_registers csr_core_registers_i (.clock(clock), .reset(reset), .avl_req(avl_req),
      .avl_rsp(avl_rsp), .core_op(core_op), .core_out(core_out));
   csr_core_model csr_core_model_i (.clock(clock), .core_op(core_op));
   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // avalon transfer held until waitrequest is seen low, then one idle cycle
   task automatic bus(input logic w, b, input logic [7:0] idx, wd, output logic [7:0] rd);
      avl_req.read <= ~w;
      avl_req.write <= w;
      avl_req.address <= {b, idx, 2'b00};
      avl_req.writedata <= {24'h00_0000, wd};
      do @(posedge clock); while (avl_rsp.waitrequest !== 1'b0);
      rd = avl_rsp.readdata[7:0];
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic b, input logic [7:0] idx, d);
      logic [7:0] x;
      bus(1'b1, b, idx, d, x);
   endtask
   task automatic rdc(input logic b, input logic [7:0] idx, exp);
      logic [7:0] d;
      bus(1'b0, b, idx, 8'h00, d);
      `CHK(d, exp)
   endtask
   task automatic alu_chk(input csr_alu_kind_t k, input logic [7:0] a, b, input logic c,
                          input logic [7:0] exp);
      csr_core_model_i.alu(k, a, b, c);
      `CHK(core_out.status, exp)
   endtask
   task automatic sys_chk(input logic h, r, t, input logic [7:0] exp);
      csr_core_model_i.pulse(h, r, t);
      `CHK(core_out.status, exp)
   endtask
   // ==========================================
   // scenarios
   task automatic test_flags();
      rdc(1'b0, IDX_STATUS, STATUS_RESET);
      alu_chk(ALU_ADD, 8'h80, 8'h80, 1'b0, 8'h8D);
      alu_chk(ALU_ADD, 8'h0F, 8'h01, 1'b0, 8'h02);
      alu_chk(ALU_ADD, 8'h7F, 8'h01, 1'b0, 8'h0A);
      `CHK(core_out.working_register, 8'h80)
      rdc(1'b0, IDX_WORKING, 8'h80);
      alu_chk(ALU_SUB, 8'h05, 8'h05, 1'b1, 8'h47);
      alu_chk(ALU_SBC, 8'h05, 8'h05, 1'b1, 8'h47);
      alu_chk(ALU_SBC, 8'h03, 8'h05, 1'b1, 8'h80);
      alu_chk(ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h84);
      alu_chk(ALU_ROTATE, 8'h80, 8'h00, 1'b0, 8'h85);
   endtask
   task automatic test_system_flags();
      wr(1'b0, IDX_STATUS, 8'hFF);
      rdc(1'b0, IDX_STATUS, 8'hCF);
      sys_chk(1'b1, 1'b0, 1'b0, 8'hDF);
      sys_chk(1'b0, 1'b0, 1'b1, 8'hFF);
      sys_chk(1'b1, 1'b0, 1'b0, 8'hDF);
      sys_chk(1'b0, 1'b0, 1'b1, 8'hFF);
      wr(1'b0, IDX_STATUS, 8'h00);
      rdc(1'b0, IDX_STATUS, 8'h30);
      sys_chk(1'b0, 1'b1, 1'b0, 8'h00);
   endtask
   task automatic test_indirect();
      rdc(1'b0, IDX_POINTER_BANK0, REG_RESET);
      wr(1'b0, IDX_POINTER_BANK0, 8'h80);
      wr(1'b1, IDX_PORT_BANK0, 8'hA5);
      rdc(1'b0, 8'h80, 8'hA5);
      rdc(1'b0, IDX_POINTER_BANK0, 8'h80);
      wr(1'b0, IDX_POINTER_ONE_LOW, 8'h80);
      wr(1'b0, IDX_POINTER_ONE_BANK, 8'h01);
      wr(1'b0, IDX_PORT_ONE, 8'h5A);
      rdc(1'b1, 8'h80, 8'h5A);
      rdc(1'b0, 8'h80, 8'hA5);
      rdc(1'b0, IDX_POINTER_ONE_BANK, 8'h01);
      wr(1'b0, IDX_POINTER_TWO_LOW, IDX_PORT_TWO);
      wr(1'b0, IDX_PORT_TWO, 8'h77);
      rdc(1'b0, IDX_PORT_TWO, INDIRECT_NULL_DATA);
      rdc(1'b0, IDX_POINTER_TWO_LOW, IDX_PORT_TWO);
      wr(1'b0, IDX_POINTER_TWO_BANK, 8'h01);
      wr(1'b0, IDX_POINTER_TWO_LOW, 8'h81);
      wr(1'b0, IDX_PORT_TWO, 8'h3C);
      rdc(1'b1, 8'h81, 8'h3C);
      rdc(1'b0, IDX_POINTER_TWO_BANK, 8'h01);
      wr(1'b0, 8'h0B, 8'hFF);
      rdc(1'b0, 8'h0B, 8'h00);
   endtask
   task automatic test_jump_table();
      // bus task returns one edge after acceptance, the jump cycle
      wr(1'b0, IDX_PC_LOW, 8'h34);
      `CHK(core_out.jump, 1'b1)
      `CHK(core_out.jump_target, 12'hA34)
      @(posedge clock);
      `CHK(core_out.dummy_cycle, 1'b1)
      `CHK(core_out.status, 8'h00)
      wr(1'b0, IDX_TABLE_LOW, 8'h12);
      wr(1'b0, IDX_TABLE_HIGH, 8'h34);
      `CHK(core_out.table_address, 16'h3412)
      csr_core_model_i.table_fetch(16'hBEEF);
      `CHK(core_out.table_low_data, 8'hEF)
      rdc(1'b0, IDX_TABLE_BYTE, 8'hBE);
   endtask
   // main sequence
   initial begin
      reset = 1'b1;
      avl_req = '{byteenable: 4'hF, default: '0};
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      test_flags();
      test_system_flags();
      test_indirect();
      test_jump_table();
      print_verdict();
   end
endmodule
